// >>> common/sta_defs.svh
// sta_defs.svh: register map, command codes, status codes and field positions
`ifndef STA_DEFS_SVH
`define STA_DEFS_SVH
// register byte offsets
`define STA_CMD_OFF 8'h00
`define STA_DATA_OFF 8'h04
`define STA_RES_OFF 8'h08
`define STA_CTRL_OFF 8'h0C
`define STA_ACK_OFF 8'h10
`define STA_STAT_OFF 8'h14
`define STA_ADDR_OFF 8'h18
`define STA_LAST_OFF 8'h18
// reset values
`define STA_ADDR_RST 8'h00
`define STA_BYTE_RST 8'h00
// command codes
`define STA_OP_PREP 8'h60
`define STA_OP_DRST 8'h6F
`define STA_OP_WRAP 8'h6E
`define STA_OP_WR 7'h28
`define STA_OP_RD 7'h08
`define STA_OP_ID 8'h20
// identification byte, value is arbitrary
`define STA_DEV_ID 8'hA5
// condition codes
`define STA_CC_NONE 3'h0
`define STA_CC_BUSY 3'h1
`define STA_CC_EXC 3'h2
`define STA_CC_DEV 3'h3
`define STA_CC_ATTN 3'h4
`define STA_CC_REJ 3'h3
`define STA_CC_IDC 3'h5
`define STA_CC_AEXC 3'h6
`define STA_CC_OK 3'h7
`define STA_CC_ADEV 3'h7
// field positions
`define STA_PND_ATTN 0
`define STA_PND_EXC 1
`define STA_PND_DEV 2
`define STA_CMD_PAR 16
`define STA_CTRL_HALT 0
`define STA_CTRL_ACK 1
`endif

// >>> common/sta_pkg.sv
// sta_pkg: types shared by the adapter modules
`default_nettype none
package sta_pkg;
	typedef enum logic [1:0] {STA_RX_IDLE, STA_RX_NORMAL, STA_RX_OVERRUN} sta_rx_t;
	typedef logic [2:0] sta_cc_t;
endpackage
`default_nettype wire

// >>> common/sta_regbus_if.sv
// sta_regbus_if: register access between bus slave and adapter core
`default_nettype none
interface sta_regbus_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	modport slave (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport core (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> logic/sta_axi_slave.sv
// sta_axi_slave: AXI4-Lite slave feeding the adapter register bus
`include "sta_defs.svh"
`default_nettype none
module sta_axi_slave import sta_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	sta_regbus_if.slave bus
);
	logic aw_full;
	logic w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_ok;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= `STA_LAST_OFF);
	endfunction

	assign awready_o = !aw_full && !bvalid_o;
	assign wready_o = !w_full && !bvalid_o;
	assign arready_o = !rvalid_o;
	assign wr_ok = mapped(aw_addr) && (w_strb == 4'hF);
	assign bus.wr_en = aw_full && w_full && wr_ok;
	assign bus.wr_addr = aw_addr;
	assign bus.wr_data = w_data;
	assign bus.rd_addr = araddr_i;

	// ==========================================
	// write channels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid_o <= 1'b0;
			bresp_o <= 2'h0;
		end else begin
			if (awvalid_i && awready_o) begin
				aw_full <= 1'b1;
				aw_addr <= awaddr_i;
			end
			if (wvalid_i && wready_o) begin
				w_full <= 1'b1;
				w_data <= wdata_i;
				w_strb <= wstrb_i;
			end
			if (aw_full && w_full) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid_o <= 1'b1;
				bresp_o <= wr_ok ? 2'h0 : 2'h2;
			end else if (bvalid_o && bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	// ==========================================
	// read channels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rvalid_o <= 1'b0;
			rdata_o <= 32'h0000_0000;
			rresp_o <= 2'h0;
		end else if (arvalid_i && arready_o) begin
			rvalid_o <= 1'b1;
			rdata_o <= mapped(araddr_i) ? bus.rd_data : 32'h0000_0000;
			rresp_o <= mapped(araddr_i) ? 2'h0 : 2'h2;
		end else if (rvalid_o && rready_i) begin
			rvalid_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> logic/sta_irq.sv
// sta_irq: pending interrupt flags and acceptance code
`include "sta_defs.svh"
`default_nettype none
module sta_irq import sta_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] set_i,
	input wire logic clr_i,
	input wire logic ack_i,
	output logic [2:0] pend_o,
	output var sta_cc_t ack_cc_o
);
	sta_cc_t next_cc;
	logic [2:0] ack_mask;
	wire logic attn = pend_o[`STA_PND_ATTN];
	wire logic exc = pend_o[`STA_PND_EXC];
	wire logic dev = pend_o[`STA_PND_DEV];

	// exception outranks device end and leaves it pending
	always_comb begin
		next_cc = `STA_CC_NONE;
		ack_mask = 3'h0;
		if (exc) begin
			next_cc = attn ? `STA_CC_AEXC : `STA_CC_EXC;
			ack_mask = 3'h3;
		end else if (attn && dev) begin
			next_cc = `STA_CC_ADEV;
			ack_mask = 3'h5;
		end else if (attn) begin
			next_cc = `STA_CC_ATTN;
			ack_mask = 3'h1;
		end else if (dev) begin
			next_cc = `STA_CC_DEV;
			ack_mask = 3'h4;
		end
	end

	// a new event wins over the acceptance that clears it
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			pend_o <= 3'h0;
		end else begin
			pend_o <= (pend_o & ~(ack_i ? ack_mask : 3'h0)) | set_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			ack_cc_o <= `STA_CC_NONE;
		end else if (ack_i) begin
			ack_cc_o <= next_cc;
		end
	end

	exc_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_i && exc && dev && !clr_i
		|=> (ack_cc_o == `STA_CC_EXC || ack_cc_o == `STA_CC_AEXC) && pend_o[`STA_PND_DEV])
		else $error("exception not reported ahead of device end");
endmodule
`default_nettype wire

// >>> logic/sta_top.sv
// sta_top: command interpreter of the serial terminal adapter
`include "sta_defs.svh"
`default_nettype none
module sta_top import sta_pkg::*; (
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	output logic [7:0] TX_DATA_O,
	output logic TX_START_O,
	input wire logic TX_DONE_I,
	input wire logic RX_START_I,
	input wire logic RX_DONE_I,
	input wire logic [7:0] RX_DATA_I,
	output logic WR_CTL_O,
	output logic RD_CTL_O,
	output logic IRQ_REQ_O,
	output logic [3:0] IRQ_LEVEL_O
);
	sta_regbus_if bus ();

	// ==========================================
	// state
	logic [31:0] cmd_word;
	logic [15:0] imm_data;
	logic [7:0] dev_addr;
	sta_cc_t res_cc;
	logic [7:0] res_byte;
	logic irq_en;
	logic [3:0] irq_lvl;
	logic [7:0] tx_hold;
	logic tx_busy;
	logic [7:0] rx_hold;
	logic rx_unread;
	sta_rx_t rx_state;
	logic wrap;
	logic [2:0] pend;
	sta_cc_t ack_cc;

	// ==========================================
	// command decode
	logic cmd_go;
	logic addr_ok;
	logic [7:0] op;
	logic par_err;
	logic mod_bit;
	logic halt;
	logic ack_req;
	logic do_prep;
	logic do_drst;
	logic do_wrap;
	logic do_write;
	logic do_read;
	logic wr_busy;
	logic rd_busy;
	logic any_busy;
	logic clr;
	sta_cc_t next_cc;
	logic [7:0] next_byte;

	assign cmd_go = bus.wr_en && (bus.wr_addr == `STA_CMD_OFF);
	assign op = bus.wr_data[7:0];
	assign par_err = bus.wr_data[`STA_CMD_PAR];
	assign mod_bit = op[0];
	assign addr_ok = bus.wr_data[15:8] == dev_addr;
	assign halt = bus.wr_en && (bus.wr_addr == `STA_CTRL_OFF) && bus.wr_data[`STA_CTRL_HALT];
	assign ack_req = bus.wr_en && (bus.wr_addr == `STA_CTRL_OFF) && bus.wr_data[`STA_CTRL_ACK];
	assign wr_busy = tx_busy || pend[`STA_PND_DEV];
	assign rd_busy = (rx_state == STA_RX_NORMAL) || pend[`STA_PND_ATTN] || pend[`STA_PND_EXC];
	assign any_busy = tx_busy || (rx_state == STA_RX_NORMAL) || (pend != 3'h0);

	always_comb begin
		next_cc = `STA_CC_NONE;
		next_byte = `STA_BYTE_RST;
		do_prep = 1'b0;
		do_drst = 1'b0;
		do_wrap = 1'b0;
		do_write = 1'b0;
		do_read = 1'b0;
		if (cmd_go && addr_ok) begin
			if (op == `STA_OP_PREP) begin
				next_cc = par_err ? `STA_CC_IDC : `STA_CC_OK;
				do_prep = !par_err;
			end else if (op == `STA_OP_DRST) begin
				next_cc = `STA_CC_OK;
				do_drst = 1'b1;
			end else if (op == `STA_OP_WRAP) begin
				next_cc = `STA_CC_OK;
				do_wrap = 1'b1;
			end else if (op[7:1] == `STA_OP_WR) begin
				if (par_err) begin
					next_cc = `STA_CC_IDC;
				end else if (wr_busy) begin
					next_cc = `STA_CC_BUSY;
				end else begin
					next_cc = `STA_CC_OK;
					do_write = 1'b1;
				end
			end else if (op[7:1] == `STA_OP_RD) begin
				if (par_err) begin
					next_cc = `STA_CC_IDC;
				end else if (rd_busy) begin
					next_cc = `STA_CC_BUSY;
				end else begin
					next_cc = `STA_CC_OK;
					next_byte = rx_hold;
					do_read = 1'b1;
				end
			end else if (op == `STA_OP_ID) begin
				next_cc = par_err ? `STA_CC_IDC : `STA_CC_OK;
				next_byte = par_err ? `STA_BYTE_RST : `STA_DEV_ID;
			end else if (par_err) begin
				next_cc = `STA_CC_IDC;
			end else begin
				next_cc = any_busy ? `STA_CC_BUSY : `STA_CC_REJ;
			end
		end
	end

	// halt, device reset and wrap reset all share one clear
	assign clr = halt || do_drst || do_wrap;

	// ==========================================
	// receive path, fed by the transmitter while wrapped
	logic tx_done;
	logic rx_start;
	logic rx_done;
	logic [7:0] rx_byte;
	logic rx_norm_end;
	logic rx_ovr_end;

	assign tx_done = TX_DONE_I && tx_busy && !clr;
	assign rx_start = wrap ? do_write : RX_START_I;
	assign rx_done = (wrap ? tx_done : RX_DONE_I) && !clr;
	assign rx_byte = wrap ? tx_hold : RX_DATA_I;
	assign rx_norm_end = rx_done && (rx_state == STA_RX_NORMAL);
	assign rx_ovr_end = rx_done && (rx_state == STA_RX_OVERRUN);

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I || clr) begin
			rx_state <= STA_RX_IDLE;
		end else begin
			case (rx_state)
				STA_RX_IDLE: begin
					if (rx_start) begin
						rx_state <= rx_unread ? STA_RX_OVERRUN : STA_RX_NORMAL;
					end
				end
				default: begin
					if (rx_done) begin
						rx_state <= STA_RX_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I || clr) begin
			rx_hold <= `STA_BYTE_RST;
		end else if (rx_norm_end) begin
			rx_hold <= rx_byte;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I || clr) begin
			rx_unread <= 1'b0;
		end else if (rx_norm_end) begin
			rx_unread <= 1'b1;
		end else if (do_read) begin
			rx_unread <= 1'b0;
		end
	end

	// ==========================================
	// transmit path
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I || halt || do_wrap) begin
			tx_hold <= `STA_BYTE_RST;
		end else if (do_write) begin
			tx_hold <= imm_data[7:0];
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I || clr) begin
			tx_busy <= 1'b0;
			TX_START_O <= 1'b0;
		end else begin
			TX_START_O <= do_write;
			if (do_write) begin
				tx_busy <= 1'b1;
			end else if (tx_done) begin
				tx_busy <= 1'b0;
			end
		end
	end
	assign TX_DATA_O = tx_hold;

	// ==========================================
	// control lines, wrap state, prepare register
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I || clr) begin
			WR_CTL_O <= 1'b0;
			RD_CTL_O <= 1'b0;
		end else begin
			if (do_write) begin
				WR_CTL_O <= mod_bit;
			end
			if (do_read) begin
				RD_CTL_O <= mod_bit;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I || halt || do_drst) begin
			wrap <= 1'b0;
		end else if (do_wrap) begin
			wrap <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			irq_en <= 1'b0;
			irq_lvl <= 4'h0;
		end else if (do_prep) begin
			irq_en <= imm_data[0];
			irq_lvl <= imm_data[4:1];
		end
	end

	// ==========================================
	// interrupts and status codes
	sta_irq u_irq (
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.set_i({tx_done, rx_ovr_end, rx_norm_end}),
		.clr_i(clr),
		.ack_i(ack_req && IRQ_REQ_O && !clr),
		.pend_o(pend),
		.ack_cc_o(ack_cc)
	);
	assign IRQ_REQ_O = irq_en && (pend != 3'h0);
	assign IRQ_LEVEL_O = irq_lvl;

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I || halt) begin
			res_cc <= `STA_CC_NONE;
			res_byte <= `STA_BYTE_RST;
		end else if (cmd_go) begin
			res_cc <= next_cc;
			res_byte <= next_byte;
		end
	end

	// ==========================================
	// software registers
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			cmd_word <= 32'h0000_0000;
			imm_data <= 16'h0000;
			dev_addr <= `STA_ADDR_RST;
		end else if (bus.wr_en) begin
			if (bus.wr_addr == `STA_CMD_OFF) begin
				cmd_word <= {15'h0000, bus.wr_data[16:0]};
			end else if (bus.wr_addr == `STA_DATA_OFF) begin
				imm_data <= bus.wr_data[15:0];
			end else if (bus.wr_addr == `STA_ADDR_OFF) begin
				dev_addr <= bus.wr_data[7:0];
			end
		end
	end

	always_comb begin
		bus.rd_data = 32'h0000_0000;
		if (bus.rd_addr == `STA_CMD_OFF) begin
			bus.rd_data = cmd_word;
		end else if (bus.rd_addr == `STA_DATA_OFF) begin
			bus.rd_data = {16'h0000, imm_data};
		end else if (bus.rd_addr == `STA_RES_OFF) begin
			bus.rd_data = {16'h0000, res_byte, 5'h00, res_cc};
		end else if (bus.rd_addr == `STA_ACK_OFF) begin
			bus.rd_data = {29'h0000_0000, ack_cc};
		end else if (bus.rd_addr == `STA_STAT_OFF) begin
			bus.rd_data = {17'h0_0000, rx_unread, irq_lvl, irq_en, RD_CTL_O, WR_CTL_O, wrap,
				pend, rx_state == STA_RX_OVERRUN, rx_state == STA_RX_NORMAL, tx_busy};
		end else if (bus.rd_addr == `STA_ADDR_OFF) begin
			bus.rd_data = {24'h00_0000, dev_addr};
		end
	end

	sta_axi_slave u_axi (
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.awaddr_i(S_AXI_AWADDR_I),
		.awvalid_i(S_AXI_AWVALID_I),
		.awready_o(S_AXI_AWREADY_O),
		.wdata_i(S_AXI_WDATA_I),
		.wstrb_i(S_AXI_WSTRB_I),
		.wvalid_i(S_AXI_WVALID_I),
		.wready_o(S_AXI_WREADY_O),
		.bresp_o(S_AXI_BRESP_O),
		.bvalid_o(S_AXI_BVALID_O),
		.bready_i(S_AXI_BREADY_I),
		.araddr_i(S_AXI_ARADDR_I),
		.arvalid_i(S_AXI_ARVALID_I),
		.arready_o(S_AXI_ARREADY_O),
		.rdata_o(S_AXI_RDATA_O),
		.rresp_o(S_AXI_RRESP_O),
		.rvalid_o(S_AXI_RVALID_O),
		.rready_i(S_AXI_RREADY_I),
		.bus(bus)
	);

	// ==========================================
	// checks
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence ovr_begin;
		rx_start && !clr && rx_state == STA_RX_IDLE && rx_unread;
	endsequence
	sequence ovr_end;
		rx_state == STA_RX_OVERRUN && rx_done;
	endsequence

	addr_match_a: assert property (cmd_go && !addr_ok && !halt |=> res_cc == `STA_CC_NONE)
		else $error("command answered at wrong address");
	prep_store_a: assert property (do_prep |=> irq_en == $past(imm_data[0]) && irq_lvl == $past(imm_data[4:1]))
		else $error("prepare not stored");
	prep_busy_a: assert property (cmd_go && addr_ok && op == `STA_OP_PREP |=> res_cc != `STA_CC_BUSY)
		else $error("prepare answered busy");
	reset_cc_a: assert property (do_drst || do_wrap |=> res_cc == `STA_CC_OK)
		else $error("reset command not satisfactory");
	drst_clear_a: assert property (do_drst |=> !WR_CTL_O && !RD_CTL_O && pend == 3'h0 && !wrap && rx_hold == 8'h00)
		else $error("device reset left state");
	wrap_enter_a: assert property (do_wrap |=> wrap && tx_hold == 8'h00 && !tx_busy)
		else $error("wrap entry wrong");
	write_busy_a: assert property (cmd_go && addr_ok && op[7:1] == `STA_OP_WR && !par_err && wr_busy
		|=> res_cc == `STA_CC_BUSY && !TX_START_O)
		else $error("busy write executed");
	tx_start_a: assert property (do_write |=> TX_START_O && TX_DATA_O == $past(imm_data[7:0])
		&& WR_CTL_O == $past(mod_bit))
		else $error("write not started");
	read_data_a: assert property (do_read |=> res_byte == $past(rx_hold) && RD_CTL_O == $past(mod_bit))
		else $error("read result wrong");
	hold_keep_a: assert property (!rx_norm_end && !clr |=> $stable(rx_hold))
		else $error("held byte changed");
	overrun_a: assert property (ovr_end |=> pend[`STA_PND_EXC] && $stable(rx_hold))
		else $error("overrun handling wrong");
	overrun_enter_a: assert property (ovr_begin |=> rx_state == STA_RX_OVERRUN)
		else $error("overrun not entered");
	irq_gate_a: assert property (IRQ_REQ_O |-> irq_en && IRQ_LEVEL_O == irq_lvl)
		else $error("interrupt while disabled");
endmodule
`default_nettype wire

// >>> bench/sta_serial_model.sv
// sta_serial_model: far-side serial device, completes transmit frames after a delay and sends characters
`default_nettype none
module sta_serial_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tx_start_i,
	input wire logic [7:0] tx_data_i,
	input wire logic [4:0] tx_delay_i,
	output logic tx_done_o,
	input wire logic rx_begin_i,
	input wire logic rx_end_i,
	input wire logic [7:0] rx_byte_i,
	output logic rx_start_o,
	output logic rx_done_o,
	output logic [7:0] rx_data_o,
	output logic [7:0] last_tx_o,
	output logic [7:0] tx_count_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] left;
	// ==========================================
	// transmit side: frame ends after a variable delay
	always_ff @(posedge clk_i) begin
		tx_done_o <= 1'b0;
		if (rst_i) begin
			left <= 6'h00;
			tx_count_o <= 8'h00;
			last_tx_o <= 8'h00;
		end else if (tx_start_i) begin
			left <= {1'b0, tx_delay_i} + 6'h01;
			last_tx_o <= tx_data_i;
			tx_count_o <= tx_count_o + 8'h01;
		end else if (left != 6'h00) begin
			left <= left - 6'h01;
			tx_done_o <= (left == 6'h01);
		end
	end
	// ==========================================
	// receive side: data line toggles outside the valid cycle
	always_ff @(posedge clk_i) begin
		rx_start_o <= rx_begin_i;
		rx_done_o <= rx_end_i;
		if (rst_i) begin
			rx_data_o <= 8'h00;
		end else begin
			rx_data_o <= rx_end_i ? rx_byte_i : ~rx_data_o;
		end
	end
endmodule
`default_nettype wire

// >>> bench/test_serial_terminal_adapter_cmds.sv
// test_serial_terminal_adapter_cmds: self-checking bench of the adapter command logic
`include "sta_defs.svh"
`default_nettype none
module test_serial_terminal_adapter_cmds import sta_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, dev, tgt, rbyte, b, b1, lvl, op;
	logic [31:0] wdata = 32'h0, v;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, tx_start, tx_done, rx_start, rx_done, wr_ctl, rd_ctl, irq, p;
	logic [1:0] b_resp, r_resp, r;
	logic [31:0] r_data;
	logic [7:0] tx_data, rx_data, last_tx, tx_count, rx_byte = 8'h00;
	logic [3:0] irq_lvl;
	logic [4:0] tx_delay = 5'h1F;
	logic rx_begin = 1'b0, rx_end = 1'b0;
	sta_cc_t cc;
	int fail_count = 0, n_tests = 0, seed;
	logic [7:0] tbl [8] = '{8'h60, 8'h6F, 8'h6E, 8'h50, 8'h51, 8'h10, 8'h11, 8'h20};
	always #20 clk = ~clk;
	sta_top DUT (.CORE_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(aw_rdy), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(w_rdy), .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_vld), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(ar_rdy), .S_AXI_RDATA_O(r_data),
		.S_AXI_RRESP_O(r_resp), .S_AXI_RVALID_O(r_vld), .S_AXI_RREADY_I(rready), .TX_DATA_O(tx_data),
		.TX_START_O(tx_start), .TX_DONE_I(tx_done), .RX_START_I(rx_start), .RX_DONE_I(rx_done),
		.RX_DATA_I(rx_data), .WR_CTL_O(wr_ctl), .RD_CTL_O(rd_ctl), .IRQ_REQ_O(irq), .IRQ_LEVEL_O(irq_lvl));
	sta_serial_model partner (.clk_i(clk), .rst_i(rst), .tx_start_i(tx_start), .tx_data_i(tx_data),
		.tx_delay_i(tx_delay), .tx_done_o(tx_done), .rx_begin_i(rx_begin), .rx_end_i(rx_end),
		.rx_byte_i(rx_byte), .rx_start_o(rx_start), .rx_done_o(rx_done), .rx_data_o(rx_data),
		.last_tx_o(last_tx), .tx_count_o(tx_count));
	// ==========================================
	// checking and closing
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	function automatic logic [2:0] exp_cc(input logic [7:0] c, input logic par);
		if (c == `STA_OP_DRST || c == `STA_OP_WRAP) return `STA_CC_OK;
		if (par) return `STA_CC_IDC;
		if (c == `STA_OP_PREP || c == `STA_OP_ID || c[7:1] == `STA_OP_WR || c[7:1] == `STA_OP_RD) return `STA_CC_OK;
		return `STA_CC_REJ;
	endfunction
	function automatic logic [2:0] exp_ack(input logic a, input logic e, input logic d);
		if (e) return a ? 3'h6 : 3'h2;
		if (a) return d ? 3'h7 : 3'h4;
		return d ? 3'h3 : 3'h0;
	endfunction
	// ==========================================
	// bus master
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic ta, tw, pa, pw, bb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			ta = pa && aw_rdy;
			tw = pw && w_rdy;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do begin
			@(negedge clk);
			bb = b_vld;
			resp = b_resp;
			@(posedge clk);
		end while (bb !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic t;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			t = ar_rdy;
			@(posedge clk);
		end while (t !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(negedge clk);
			t = r_vld;
			d = r_data;
			resp = r_resp;
			@(posedge clk);
		end while (t !== 1'b1);
		rready <= 1'b0;
	endtask
	// ==========================================
	// command, interrupt and receive helpers
	task automatic cx(input logic [7:0] c, input logic [7:0] d, input logic par, input logic [2:0] exp);
		logic [31:0] res;
		axi_wr(`STA_DATA_OFF, {24'h0, d}, r);
		axi_wr(`STA_CMD_OFF, {15'h0, par, tgt, c}, r);
		axi_rd(`STA_RES_OFF, res, r);
		rbyte = res[15:8];
		check("condition code", res[2:0], exp);
	endtask
	task automatic ack(input logic [2:0] exp);
		axi_wr(`STA_CTRL_OFF, 32'h2, r);
		axi_rd(`STA_ACK_OFF, v, r);
		check("accept code", v[2:0], exp);
	endtask
	task automatic wait_irq;
		for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge clk);
		check("irq request", irq, 1'b1);
	endtask
	task automatic rx(input logic st, input logic en, input logic [7:0] bt);
		@(posedge clk);
		rx_begin <= st;
		@(posedge clk);
		rx_begin <= 1'b0;
		repeat (5) @(posedge clk);
		rx_end <= en;
		rx_byte <= bt;
		@(posedge clk);
		rx_end <= 1'b0;
	endtask
	// ==========================================
	// watchdog
	initial begin
		#(40 * 40000);
		fail_count++;
		report_and_stop();
	end
	// ==========================================
	// main sequence
	initial begin
		seed = $urandom(7);
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		axi_rd(`STA_ADDR_OFF, v, r);
		check("devaddr", v, 32'h0);
		axi_rd(8'h1C, v, r);
		check("unmapped", r, 2'b10);
		axi_wr(8'h1C, 32'h0, r);
		check("unmapped write", r, 2'b10);
		dev = 8'($urandom);
		axi_wr(`STA_ADDR_OFF, {24'h0, dev}, r);
		check("write resp", r, 2'b00);
		tgt = dev + 8'h01;
		cx(`STA_OP_ID, 8'h00, 1'b0, `STA_CC_NONE);
		tgt = dev;
		lvl = 8'($urandom_range(0, 3));
		cx(`STA_OP_PREP, {lvl[6:0], 1'b1}, 1'b0, `STA_CC_OK);
		check("level", irq_lvl, lvl[3:0]);
		cx(`STA_OP_PREP, 8'h1E, 1'b1, `STA_CC_IDC);
		check("level kept", irq_lvl, lvl[3:0]);
		cx(`STA_OP_ID, 8'h00, 1'b0, `STA_CC_OK);
		check("id byte", rbyte, `STA_DEV_ID);
		cx(`STA_OP_ID, 8'h00, 1'b1, `STA_CC_IDC);
		cx(8'h33, 8'h00, 1'b0, `STA_CC_REJ);
		b = 8'($urandom);
		cx({`STA_OP_WR, 1'b1}, b, 1'b0, `STA_CC_OK);
		repeat (3) @(posedge clk);
		check("write ctl", wr_ctl, 1'b1);
		check("sent byte", last_tx, b);
		cx({`STA_OP_WR, 1'b0}, ~b, 1'b0, `STA_CC_BUSY);
		wait_irq();
		cx(8'h33, 8'h00, 1'b0, `STA_CC_BUSY);
		cx({`STA_OP_WR, 1'b1}, ~b, 1'b0, `STA_CC_BUSY);
		check("tx count", tx_count, 8'h01);
		ack(exp_ack(0, 0, 1));
		b1 = 8'($urandom);
		rx(1'b1, 1'b1, b1);
		wait_irq();
		cx({`STA_OP_RD, 1'b1}, 8'h00, 1'b0, `STA_CC_BUSY);
		ack(exp_ack(1, 0, 0));
		rx(1'b1, 1'b0, 8'h00);
		cx({`STA_OP_RD, 1'b1}, 8'h00, 1'b0, `STA_CC_OK);
		check("read byte", rbyte, b1);
		check("read ctl", rd_ctl, 1'b1);
		tx_delay <= 5'($urandom);
		cx({`STA_OP_WR, 1'b0}, b, 1'b0, `STA_CC_OK);
		rx(1'b0, 1'b1, ~b1);
		repeat (60) @(posedge clk);
		check("write ctl", wr_ctl, 1'b0);
		ack(exp_ack(0, 1, 1));
		ack(exp_ack(0, 0, 1));
		cx({`STA_OP_RD, 1'b0}, 8'h00, 1'b0, `STA_CC_OK);
		check("held byte", rbyte, b1);
		check("read ctl", rd_ctl, 1'b0);
		rx(1'b1, 1'b1, b);
		wait_irq();
		ack(exp_ack(1, 0, 0));
		cx({`STA_OP_RD, 1'b0}, 8'h00, 1'b0, `STA_CC_OK);
		check("new byte", rbyte, b);
		tx_delay <= 5'h1F;
		cx({`STA_OP_WR, 1'b1}, b1, 1'b0, `STA_CC_OK);
		cx(`STA_OP_DRST, 8'h00, 1'b1, `STA_CC_OK);
		check("write ctl", wr_ctl, 1'b0);
		check("tx byte kept", tx_data, b1);
		repeat (40) @(posedge clk);
		check("no irq", irq, 1'b0);
		rx(1'b1, 1'b1, b);
		wait_irq();
		axi_wr(`STA_CTRL_OFF, 32'h1, r);
		check("halt irq", irq, 1'b0);
		check("halt tx byte", tx_data, 8'h00);
		check("halt level", irq_lvl, lvl[3:0]);
		cx(`STA_OP_WRAP, 8'h00, 1'b1, `STA_CC_OK);
		axi_rd(`STA_STAT_OFF, v, r);
		check("wrap state", v[6], 1'b1);
		tx_delay <= 5'h00;
		cx({`STA_OP_WR, 1'b0}, b1, 1'b0, `STA_CC_OK);
		repeat (20) @(posedge clk);
		ack(exp_ack(1, 0, 1));
		cx({`STA_OP_WR, 1'b0}, b, 1'b0, `STA_CC_OK);
		repeat (20) @(posedge clk);
		ack(exp_ack(0, 1, 1));
		ack(exp_ack(0, 0, 1));
		cx({`STA_OP_RD, 1'b0}, 8'h00, 1'b0, `STA_CC_OK);
		check("looped byte", rbyte, b1);
		cx(`STA_OP_DRST, 8'h00, 1'b0, `STA_CC_OK);
		axi_rd(`STA_STAT_OFF, v, r);
		check("wrap left", v[6], 1'b0);
		cx(`STA_OP_WRAP, 8'h00, 1'b0, `STA_CC_OK);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		axi_rd(`STA_STAT_OFF, v, r);
		check("wrap after reset", v[6], 1'b0);
		check("enable after reset", v[9], 1'b0);
		axi_wr(`STA_ADDR_OFF, {24'h0, dev}, r);
		for (int i = 0; i < 24; i++) begin
			op = ($urandom % 2) ? tbl[$urandom % 8] : 8'($urandom);
			p = 1'($urandom);
			if (op[7:1] == `STA_OP_WR) p = 1'b1;
			cx(op, 8'($urandom), p, exp_cc(op, p));
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
